// [rtl/rst_boot_irq.sv]
/*
 reset sequencing, boot-mode capture, external interrupt request logic and pin
 pull-up control, with an AHB-Lite register slave.
 assumes hresetn is the board reset pin and power_on_reset_n the power-on reset pin, both asynchronous, and
 that the pads resolve pull-ups and two-way pins from the enables given here.
*/
// Behaviour
// RULE1 - irq honoured asynchronously in stop or wait
// RULE2 - irq synchronized in all other modes
// RULE3 - irq level or falling edge, per software
// RULE4 - low reset input holds whole device reset
// RULE5 - boot select captured at reset release
// RULE6 - internal reset held fixed cycles, removed synchronously
// RULE7 - reset output shows internal reset state
// RULE8 - power-on reset asserts internal reset
// RULE9 - assert reset and test reset together
// RULE10 - debugger resets device only, test reset idle
// RULE11 - boot select high external, low internal boot
// RULE12 - timer d pins default timer, gpio optional
// RULE13 - disable bits switch off irq, reset pull-ups
// RULE14 - port e bits enable timer d pull-ups
// RULE15 - software disables boot and mode pull-ups
// RULE16 - memory mode selects 20-bit address bus
// RULE17 - internal boot uses 16 address lines
// RULE18 - secured flash refuses external boot
// RULE19 - sampled pins pass two-stage synchronizer
module rst_boot_irq (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic power_on_reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_irq_req_a,
   input wire logic ext_irq_req_b,
   input wire logic boot_select_in,
   input wire logic ext_mem_mode_in,
   input wire logic flash_secured,
   output logic reset_state_out,
   output logic internal_reset_n,
   output logic wake_request,
   output logic irq_service_a,
   output logic irq_service_b,
   output logic irq,
   output logic irq_pullup_en,
   output logic reset_pullup_en,
   output logic boot_select_pullup_en,
   output logic mem_mode_pullup_en,
   output logic timer_d_ch0_pullup_en,
   output logic timer_d_ch1_pullup_en,
   output logic timer_d_ch0_is_gpio,
   output logic timer_d_ch1_is_gpio,
   output logic timer_d_ch0_gpio_oe,
   output logic timer_d_ch1_gpio_oe,
   output logic timer_d_ch0_gpio_out,
   output logic timer_d_ch1_gpio_out,
   output logic [2:0] boot_mode
);
   // ==========================================================
   // reset sequencing
   logic [7:0] hold_cnt;
   logic [7:0] next_hold_cnt;
   logic rst_run;
   logic next_rst_run;
   logic any_rst_n;
   // either source holds the chip in reset asynchronously
   assign any_rst_n = hresetn & power_on_reset_n; // RULE4 RULE8

   always_comb begin
      next_hold_cnt = hold_cnt;
      next_rst_run = rst_run;
      if (!rst_run) begin
         if (hold_cnt == 8'(rst_boot_pkg::reset_hold_cycles - 1)) begin
            next_rst_run = 1'b1; // RULE6
         end else begin
            next_hold_cnt = hold_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge hclk or negedge any_rst_n) begin
      if (!any_rst_n) begin
         hold_cnt <= 8'h00;
         rst_run <= 1'b0;
      end else begin
         hold_cnt <= next_hold_cnt;
         rst_run <= next_rst_run;
      end
   end

   // ==========================================================
   // pin synchronizers
   logic [3:0] sync1;
   logic [3:0] sync2;
   always_ff @(posedge hclk or negedge any_rst_n) begin
      if (!any_rst_n) begin
         // request lines start at their idle high level, so no false edge
         sync1 <= 4'h3;
         sync2 <= 4'h3;
      end else begin
         sync1 <= {boot_select_in, ext_mem_mode_in, ext_irq_req_b, ext_irq_req_a}; // RULE19
         sync2 <= sync1;
      end
   end

   // ==========================================================
   // boot-mode capture at release
   rst_boot_pkg::boot_mode_t mode;
   rst_boot_pkg::boot_mode_t next_mode;
   always_comb begin
      next_mode = mode;
      if (!rst_run && next_rst_run) begin
         next_mode.flash_unsecured = ~flash_secured;
         next_mode.external_boot = sync2[3] & ~flash_secured; // RULE5 RULE11 RULE18
         next_mode.wide_address = sync2[3] & ~flash_secured & sync2[2]; // RULE16 RULE17
      end
   end

   // ==========================================================
   // registers
   logic [3:0] pud;
   logic [3:0] next_pud;
   logic [15:0] pe_pur;
   logic [15:0] next_pe_pur;
   logic [3:0] irq_cfg;
   logic [3:0] next_irq_cfg;
   logic [1:0] pin_fn;
   logic [1:0] next_pin_fn;
   logic [3:0] gpio_ctrl;
   logic [3:0] next_gpio_ctrl;
   logic [1:0] int_status;
   logic [1:0] next_int_status;
   logic [1:0] int_mask;
   logic [1:0] next_int_mask;
   rst_boot_pkg::power_mode_t pwr;
   rst_boot_pkg::power_mode_t next_pwr;
   logic wr_pend;
   logic next_wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic addr_ok;
   logic [7:0] a_off;

   // ==========================================================
   // interrupt request path
   rst_boot_pkg::irq_pair_t prev_lvl;
   rst_boot_pkg::irq_pair_t next_prev_lvl;
   logic [1:0] req;
   logic [1:0] next_req;
   logic low_power;
   assign low_power = (pwr == rst_boot_pkg::pwr_stop) || (pwr == rst_boot_pkg::pwr_wait);

   always_comb begin
      next_prev_lvl = {sync2[0], sync2[1]};
      for (int i = 0; i < 2; i++) begin
         if (irq_cfg[i]) begin
            // falling edge of active-low pin on synchronized level
            next_req[i] = (i == 0 ? prev_lvl.irq_a : prev_lvl.irq_b) & ~sync2[i]; // RULE3
         end else begin
            next_req[i] = ~sync2[i]; // RULE2 RULE3
         end
         next_req[i] = next_req[i] & irq_cfg[i + rst_boot_pkg::irqcfg_en_a_bit];
      end
   end

   always_ff @(posedge hclk or negedge any_rst_n) begin
      if (!any_rst_n) begin
         prev_lvl <= '1;
         req <= 2'h0;
      end else begin
         prev_lvl <= next_prev_lvl;
         req <= next_req;
      end
   end

   // ==========================================================
   // bus slave
   assign a_off = haddr[7:0];
   assign addr_ok = (haddr[31:8] == 24'h000000) && (a_off[1:0] == 2'h0)
                    && (a_off <= rst_boot_pkg::off_power_mode);

   always_comb begin
      next_wr_pend = hsel & hready & htrans[1] & hwrite & addr_ok;
      next_wr_addr = a_off;
      next_hrdata = 32'h00000000;
      next_pud = pud;
      next_pe_pur = pe_pur;
      next_irq_cfg = irq_cfg;
      next_pin_fn = pin_fn;
      next_gpio_ctrl = gpio_ctrl;
      next_int_mask = int_mask;
      next_pwr = pwr;
      next_int_status = int_status;
      if (wr_pend) begin
         case (wr_addr)
            rst_boot_pkg::off_pullup_disable: next_pud = hwdata[3:0]; // RULE13
            rst_boot_pkg::off_port_e_pullup_en: next_pe_pur = hwdata[15:0]; // RULE14
            rst_boot_pkg::off_irq_config: next_irq_cfg = hwdata[3:0];
            rst_boot_pkg::off_pin_function: next_pin_fn = hwdata[1:0]; // RULE12
            rst_boot_pkg::off_gpio_ctrl: next_gpio_ctrl = hwdata[3:0];
            rst_boot_pkg::off_int_status: next_int_status = int_status & ~hwdata[1:0];
            rst_boot_pkg::off_int_mask: next_int_mask = hwdata[1:0];
            rst_boot_pkg::off_power_mode: begin
               if (hwdata[1:0] != 2'h3) begin
                  next_pwr = rst_boot_pkg::power_mode_t'(hwdata[1:0]);
               end
            end
            default: next_pud = pud;
         endcase
      end
      // set wins over clear
      next_int_status = next_int_status | req;
      // a synchronized request leaves the low-power modes
      if (low_power && (req != 2'h0)) begin
         next_pwr = rst_boot_pkg::pwr_run;
      end
      // a read right behind a write sees the value that the write leaves
      if (hsel && hready && htrans[1] && !hwrite && addr_ok) begin
         case (a_off)
            rst_boot_pkg::off_pullup_disable: next_hrdata = {28'h0000000, next_pud};
            rst_boot_pkg::off_port_e_pullup_en: next_hrdata = {16'h0000, next_pe_pur};
            rst_boot_pkg::off_irq_config: next_hrdata = {28'h0000000, next_irq_cfg};
            rst_boot_pkg::off_mode_status: next_hrdata = {28'h0000000, req, 1'b0, rst_run};
            rst_boot_pkg::off_pin_function: next_hrdata = {30'h0000000, next_pin_fn};
            rst_boot_pkg::off_gpio_ctrl: next_hrdata = {28'h0000000, next_gpio_ctrl};
            rst_boot_pkg::off_int_status: next_hrdata = {30'h0000000, next_int_status};
            rst_boot_pkg::off_int_mask: next_hrdata = {30'h0000000, next_int_mask};
            rst_boot_pkg::off_power_mode: next_hrdata = {30'h0000000, next_pwr};
            default: next_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge any_rst_n) begin
      if (!any_rst_n) begin
         pud <= rst_boot_pkg::pullup_disable_rst;
         pe_pur <= rst_boot_pkg::port_e_pullup_en_rst; // RULE14
         irq_cfg <= rst_boot_pkg::irq_config_rst;
         pin_fn <= rst_boot_pkg::pin_function_rst; // RULE12
         gpio_ctrl <= rst_boot_pkg::gpio_ctrl_rst;
         int_status <= rst_boot_pkg::int_status_rst;
         int_mask <= rst_boot_pkg::int_mask_rst;
         pwr <= rst_boot_pkg::pwr_run;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h00000000;
         mode <= '0;
      end else begin
         pud <= next_pud;
         pe_pur <= next_pe_pur;
         irq_cfg <= next_irq_cfg;
         pin_fn <= next_pin_fn;
         gpio_ctrl <= next_gpio_ctrl;
         int_status <= next_int_status;
         int_mask <= next_int_mask;
         pwr <= next_pwr;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         mode <= next_mode;
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge hclk or negedge any_rst_n) begin
      if (!any_rst_n) begin
         reset_state_out <= 1'b0;
         internal_reset_n <= 1'b0;
         irq_service_a <= 1'b0;
         irq_service_b <= 1'b0;
         irq <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq_pullup_en <= 1'b1;
         reset_pullup_en <= 1'b1;
         boot_select_pullup_en <= 1'b1;
         mem_mode_pullup_en <= 1'b1;
         timer_d_ch0_pullup_en <= 1'b1;
         timer_d_ch1_pullup_en <= 1'b1;
         timer_d_ch0_is_gpio <= 1'b0;
         timer_d_ch1_is_gpio <= 1'b0;
         timer_d_ch0_gpio_oe <= 1'b0;
         timer_d_ch1_gpio_oe <= 1'b0;
         timer_d_ch0_gpio_out <= 1'b0;
         timer_d_ch1_gpio_out <= 1'b0;
         boot_mode <= 3'h0;
      end else begin
         reset_state_out <= next_rst_run; // RULE7
         internal_reset_n <= next_rst_run; // RULE6
         irq_service_a <= next_req[0];
         irq_service_b <= next_req[1];
         irq <= ((next_int_status & next_int_mask) != 2'h0);
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq_pullup_en <= ~next_pud[rst_boot_pkg::pud_irq_bit]; // RULE13
         reset_pullup_en <= ~next_pud[rst_boot_pkg::pud_reset_bit]; // RULE13
         boot_select_pullup_en <= ~next_pud[rst_boot_pkg::pud_boot_bit];
         mem_mode_pullup_en <= ~next_pud[rst_boot_pkg::pud_mem_mode_bit];
         timer_d_ch0_pullup_en <= next_pe_pur[rst_boot_pkg::pe_line_10_bit]; // RULE14
         timer_d_ch1_pullup_en <= next_pe_pur[rst_boot_pkg::pe_line_11_bit]; // RULE14
         timer_d_ch0_is_gpio <= next_pin_fn[0]; // RULE12
         timer_d_ch1_is_gpio <= next_pin_fn[1]; // RULE12
         timer_d_ch0_gpio_oe <= next_pin_fn[0] & next_gpio_ctrl[0];
         timer_d_ch1_gpio_oe <= next_pin_fn[1] & next_gpio_ctrl[1];
         timer_d_ch0_gpio_out <= next_gpio_ctrl[2];
         timer_d_ch1_gpio_out <= next_gpio_ctrl[3];
         boot_mode <= next_mode;
      end
   end

   // asynchronous wake path: raw low pin requests wake without a clock
   assign wake_request = low_power & ~(ext_irq_req_a & ext_irq_req_b); // RULE1

   // ==========================================================
   // checks
   property p_reset_hold;
      @(posedge hclk) disable iff (!any_rst_n)
      $rose(internal_reset_n) |-> $past(hold_cnt) == 8'(rst_boot_pkg::reset_hold_cycles - 1);
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("reset released early"); // RULE6

   property p_reset_out;
      @(posedge hclk) disable iff (!any_rst_n)
      reset_state_out == internal_reset_n;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("reset output mismatch"); // RULE7

   property p_secure;
      @(posedge hclk) disable iff (!any_rst_n)
      boot_mode[1] |-> boot_mode[2];
   endproperty
   a_secure: assert property (p_secure) else $error("external boot while secured"); // RULE18

   property p_wide;
      @(posedge hclk) disable iff (!any_rst_n)
      boot_mode[0] |-> boot_mode[1];
   endproperty
   a_wide: assert property (p_wide) else $error("wide bus in internal boot"); // RULE17

   property p_sync;
      @(posedge hclk) disable iff (!any_rst_n)
      (!irq_cfg[0] && irq_cfg[2] && !ext_irq_req_a) [*3] |=> irq_service_a;
   endproperty
   a_sync: assert property (p_sync) else $error("level request not served"); // RULE2

   property p_edge;
      @(posedge hclk) disable iff (!any_rst_n)
      (irq_cfg[0] && irq_service_a) |=> !irq_service_a;
   endproperty
   a_edge: assert property (p_edge) else $error("edge request too long"); // RULE3

   property p_pud;
      @(posedge hclk) disable iff (!any_rst_n)
      pud[rst_boot_pkg::pud_irq_bit] |-> !irq_pullup_en;
   endproperty
   a_pud: assert property (p_pud) else $error("irq pull-up not disabled"); // RULE13

   property p_irq_out;
      @(posedge hclk) disable iff (!any_rst_n)
      ((int_status & int_mask) != 2'h0) |-> irq;
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("interrupt not raised"); // RULE2
endmodule : rst_boot_irq

// [shared/rst_boot_pkg.sv]
/*
 holds the register map, field positions, reset values and timing counts of the
 reset, boot-mode and external interrupt pin block.
 assumes one 125 MHz clock and an AHB-Lite master with single word transfers.
*/
package rst_boot_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] off_pullup_disable = 8'h00;
   localparam logic [7:0] off_port_e_pullup_en = 8'h04;
   localparam logic [7:0] off_irq_config = 8'h08;
   localparam logic [7:0] off_mode_status = 8'h0C;
   localparam logic [7:0] off_pin_function = 8'h10;
   localparam logic [7:0] off_gpio_ctrl = 8'h14;
   localparam logic [7:0] off_int_status = 8'h18;
   localparam logic [7:0] off_int_mask = 8'h1C;
   localparam logic [7:0] off_power_mode = 8'h20;
   // ==========================================================
   // field positions
   localparam int pud_irq_bit = 0;
   localparam int pud_reset_bit = 1;
   localparam int pud_boot_bit = 2;
   localparam int pud_mem_mode_bit = 3;
   localparam int pe_line_10_bit = 10;
   localparam int pe_line_11_bit = 11;
   localparam int irqcfg_edge_a_bit = 0;
   localparam int irqcfg_edge_b_bit = 1;
   localparam int irqcfg_en_a_bit = 2;
   localparam int irqcfg_en_b_bit = 3;
   // ==========================================================
   // reset values
   localparam logic [3:0] pullup_disable_rst = 4'h0;
   localparam logic [15:0] port_e_pullup_en_rst = 16'hFFFF;
   localparam logic [3:0] irq_config_rst = 4'h0;
   localparam logic [1:0] pin_function_rst = 2'h0;
   localparam logic [3:0] gpio_ctrl_rst = 4'h0;
   localparam logic [1:0] int_mask_rst = 2'h0;
   localparam logic [1:0] int_status_rst = 2'h0;
   // ==========================================================
   // timing: internal reset hold after release
   localparam int reset_hold_ns = 256;
   localparam int clk_period_ns = 8;
   localparam int reset_hold_cycles = (reset_hold_ns + clk_period_ns - 1) / clk_period_ns;
   // ==========================================================
   // operating mode and power mode
   typedef enum logic [1:0] {
      pwr_run = 2'h0,
      pwr_wait = 2'h1,
      pwr_stop = 2'h2
   } power_mode_t;
   typedef struct packed {
      logic flash_unsecured;
      logic external_boot;
      logic wide_address;
   } boot_mode_t;
   typedef struct packed {
      logic irq_a;
      logic irq_b;
   } irq_pair_t;
endpackage : rst_boot_pkg

// [tb/board_model.sv]
/*
 board side of the reset, boot strap and interrupt pins: reset switch, debug
 probe, strap resistors and interrupting devices.
 assumes the bench changes the commands just after a rising clock edge.
*/
module board_model (
   input wire logic board_rst,
   input wire logic por,
   input wire logic debug_only,
   input wire logic [1:0] irq_drive,
   input wire logic [2:0] straps,
   output logic hresetn,
   output logic power_on_reset_n,
   output logic trst_n,
   output logic ext_irq_req_a,
   output logic ext_irq_req_b,
   output logic boot_select_in,
   output logic ext_mem_mode_in,
   output logic flash_secured
);
   // ==========================================================
   // reset pins
   assign hresetn = !board_rst;
   assign trst_n = !(board_rst && !debug_only);
   assign power_on_reset_n = !por;
   // ==========================================================
   // released request lines float up to the pull-up level
   assign ext_irq_req_a = !irq_drive[0];
   assign ext_irq_req_b = !irq_drive[1];
   assign boot_select_in = straps[0];
   assign ext_mem_mode_in = straps[1];
   assign flash_secured = straps[2];
endmodule : board_model

// [tb/testbench.sv]
/*
 self-checking bench of the reset, boot-mode and interrupt pin block.
 assumes a zero wait AHB-Lite slave and the board model on the pin side.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'h0, irq_drive = 2'h0;
   logic hwrite = 1'b0, hsel = 1'b1, board_rst = 1'b1, por = 1'b0, debug_only = 1'b0;
   logic [2:0] hsize = 3'h2, straps = 3'h0, boot_mode;
   logic hready, hresp, hresetn, power_on_reset_n, irq_a, irq_b, boot_in, mem_in, secured;
   logic reset_state_out, internal_reset_n, wake_request, irq_service_a, irq_service_b, irq;
   logic pu_irq, pu_rst, pu_boot, pu_mem, pu_d0, pu_d1, gp0, gp1, oe0, oe1, out0, out1;
   logic rd_dphase = 1'b0;
   logic trst_n;
   logic [31:0] exp_q[$];
   int bad_count = 0, n_compared = 0, cycles = 0, n;
   int seed = 32'hDBD0CDD5;
   rst_boot_pkg::boot_mode_t e;
   always #4 hclk = !hclk;
   board_model partner (.board_rst(board_rst), .por(por), .debug_only(debug_only),
      .irq_drive(irq_drive), .straps(straps), .hresetn(hresetn),
      .power_on_reset_n(power_on_reset_n), .trst_n(trst_n), .ext_irq_req_a(irq_a),
      .ext_irq_req_b(irq_b), .boot_select_in(boot_in), .ext_mem_mode_in(mem_in),
      .flash_secured(secured));
   rst_boot_irq DUT (.hclk(hclk), .hresetn(hresetn), .power_on_reset_n(power_on_reset_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .ext_irq_req_a(irq_a), .ext_irq_req_b(irq_b), .boot_select_in(boot_in),
      .ext_mem_mode_in(mem_in), .flash_secured(secured), .reset_state_out(reset_state_out),
      .internal_reset_n(internal_reset_n), .wake_request(wake_request),
      .irq_service_a(irq_service_a), .irq_service_b(irq_service_b), .irq(irq),
      .irq_pullup_en(pu_irq), .reset_pullup_en(pu_rst), .boot_select_pullup_en(pu_boot),
      .mem_mode_pullup_en(pu_mem), .timer_d_ch0_pullup_en(pu_d0),
      .timer_d_ch1_pullup_en(pu_d1), .timer_d_ch0_is_gpio(gp0), .timer_d_ch1_is_gpio(gp1),
      .timer_d_ch0_gpio_oe(oe0), .timer_d_ch1_gpio_oe(oe1), .timer_d_ch0_gpio_out(out0),
      .timer_d_ch1_gpio_out(out1), .boot_mode(boot_mode));
   // ==========================================================
   // checking and closing
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask : check
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 12000) begin
         bad_count++;
         conclude();
      end
   end
   // read data is compared at the data phase edge against the oldest note
   always @(posedge hclk) begin
      if (rd_dphase && hready === 1'b1 && exp_q.size() > 0) check(hrdata, exp_q.pop_front());
      if (rd_dphase && hready === 1'b1) check(32'(hresp), 32'h0);
      if (hready === 1'b1) rd_dphase <= hsel && htrans[1] && !hwrite;
   end
   // ==========================================================
   // bus and pin tasks
   task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= 32'(addr);
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wdata;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask : ahb
   task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
      exp_q.push_back(exp);
      ahb(1'b0, addr, 32'h0);
   endtask : rd
   task automatic settle(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask : settle
   function automatic logic svc(input int i);
      return i ? irq_service_b : irq_service_a;
   endfunction : svc
   task automatic do_reset(input logic use_por, input logic [2:0] s);
      @(posedge hclk);
      if (use_por) por <= 1'b1;
      else board_rst <= 1'b1;
      straps <= s;
      settle(6);
      check(32'({internal_reset_n, reset_state_out}), 32'h0);
      if (!use_por) check(32'(trst_n), 32'(debug_only));
      @(posedge hclk);
      por <= 1'b0;
      board_rst <= 1'b0;
      n = 0;
      do begin
         settle(1);
         n++;
      end while (internal_reset_n !== 1'b1 && n < 100);
      check(32'(n), 32'(rst_boot_pkg::reset_hold_cycles));
      check(32'(reset_state_out), 32'h1);
      check(32'({pu_irq, pu_rst, pu_boot, pu_mem, pu_d0, pu_d1, gp0, gp1}), 32'hFC);
   endtask : do_reset
   // ==========================================================
   // main sequence
   logic [7:0] offs[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h40, 8'h18};
   logic [31:0] rstv[10] = '{32'h0, 32'hFFFF, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   initial begin
      do_reset(1'b0, 3'h0);
      for (int i = 0; i < 10; i++) rd(offs[i], rstv[i]);
      $display("test reset values done");
      for (int b = 0; b < 5; b++) begin
         ahb(1'b1, rst_boot_pkg::off_pullup_disable, (b < 4) ? 32'h1 << b : 32'hF);
         settle(2);
         r = (b < 4) ? {28'h0000000, ~(4'h1 << b)} : 32'h0;
         check(32'({pu_mem, pu_boot, pu_rst, pu_irq}), r);
      end
      for (int v = 0; v < 4; v++) begin
         ahb(1'b1, rst_boot_pkg::off_port_e_pullup_en, 32'(v) << 10);
         settle(2);
         check(32'({pu_d1, pu_d0}), 32'(v));
      end
      ahb(1'b1, rst_boot_pkg::off_pin_function, 32'h3);
      r = $random(seed);
      ahb(1'b1, rst_boot_pkg::off_gpio_ctrl, 32'(r[3:0]));
      settle(2);
      check(32'({gp1, gp0}), 32'h3);
      check(32'({out1, out0, oe1, oe0}), 32'(r[3:0]));
      $display("test pull-ups and pins done");
      for (int i = 0; i < 2; i++) begin
         ahb(1'b1, rst_boot_pkg::off_irq_config, 32'h4 << i);
         @(posedge hclk);
         irq_drive[i] <= 1'b1;
         settle(1);
         check(32'(svc(i)), 32'h0);
         n = 0;
         while (svc(i) !== 1'b1 && n < 8) begin
            settle(1);
            n++;
         end
         check(32'(svc(i)), 32'h1);
         @(posedge hclk);
         irq_drive[i] <= 1'b0;
         settle(8);
         ahb(1'b1, rst_boot_pkg::off_irq_config, (32'h4 << i) | (32'h1 << i));
         @(posedge hclk);
         irq_drive[i] <= 1'b1;
         n = 0;
         repeat (12) begin
            settle(1);
            if (svc(i) === 1'b1) n++;
         end
         check(32'(n), 32'h1);
         @(posedge hclk);
         irq_drive[i] <= 1'b0;
         settle(8);
      end
      rd(rst_boot_pkg::off_int_status, 32'h3);
      ahb(1'b1, rst_boot_pkg::off_int_mask, 32'h0);
      settle(3);
      check(32'(irq), 32'h0);
      ahb(1'b1, rst_boot_pkg::off_int_mask, 32'h3);
      settle(3);
      check(32'(irq), 32'h1);
      ahb(1'b1, rst_boot_pkg::off_int_status, 32'h3);
      settle(3);
      check(32'(irq), 32'h0);
      rd(rst_boot_pkg::off_int_status, 32'h0);
      $display("test interrupt requests done");
      for (int m = 1; m < 3; m++) begin
         ahb(1'b1, rst_boot_pkg::off_power_mode, 32'(m));
         rd(rst_boot_pkg::off_power_mode, 32'(m));
         @(posedge hclk);
         irq_drive[1] <= 1'b1;
         #1;
         check(32'(wake_request), 32'h1);
         settle(8);
         rd(rst_boot_pkg::off_power_mode, 32'h0);
         settle(1);
         check(32'(wake_request), 32'h0);
         @(posedge hclk);
         irq_drive[1] <= 1'b0;
         settle(4);
      end
      ahb(1'b1, rst_boot_pkg::off_power_mode, 32'h3);
      rd(rst_boot_pkg::off_power_mode, 32'h0);
      $display("test low power wake done");
      for (int c = 0; c < 8; c++) begin
         debug_only <= c[0];
         do_reset(c == 5, 3'(c));
         e.flash_unsecured = !c[2];
         e.external_boot = c[0] && !c[2];
         e.wide_address = c[0] && !c[2] && c[1];
         check(32'(boot_mode), 32'(e));
      end
      $display("test boot modes done");
      conclude();
   end
endmodule : testbench
